// >>> rtl/dnbr_top.sv
// Summary of operation
// - two independent 9-bit halves, joinable as 18
// - each half has its own controls
// - load data on rising clock when enabled
// - load enable high ignores clock edges
// - clear zeroes half three sys_clk edges later, overrides loads
// - output enable high floats outputs
// - output enable never touches storage
`default_nettype none
module dnbr_top
	import dnbr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// low half pins
	input wire logic lo_clk,
	input wire logic lo_load_enable_n,
	input wire logic lo_async_zero_n,
	input wire logic lo_oe_n,
	input wire logic [DNBR_HALF_W-1:0] lo_d,
	output logic [DNBR_HALF_W-1:0] lo_q,
	output logic lo_q_oe_n,
	// high half pins
	input wire logic hi_clk,
	input wire logic hi_load_enable_n,
	input wire logic hi_async_zero_n,
	input wire logic hi_oe_n,
	input wire logic [DNBR_HALF_W-1:0] hi_d,
	output logic [DNBR_HALF_W-1:0] hi_q,
	output logic hi_q_oe_n
);
	typedef struct packed
	{
		logic [DNBR_NUM_HALVES-1:0][DNBR_HALF_W-1:0] store;
		logic [DNBR_NUM_HALVES-1:0] drive_n;
		logic [DNBR_NUM_HALVES-1:0] clk_prev;
	} dnbr_state_t;

	dnbr_state_t st;
	dnbr_state_t next_st;
	logic [DNBR_NUM_HALVES-1:0][DNBR_PIN_W-1:0] pins;
	logic [DNBR_NUM_HALVES-1:0][DNBR_PIN_W-1:0] pins_s;
	// per-half fields after the synchroniser
	logic [DNBR_NUM_HALVES-1:0] clk_s;
	logic [DNBR_NUM_HALVES-1:0] load_n_s;
	logic [DNBR_NUM_HALVES-1:0] zero_n_s;
	logic [DNBR_NUM_HALVES-1:0] oe_n_s;
	logic [DNBR_NUM_HALVES-1:0][DNBR_HALF_W-1:0] data_s;
	logic [DNBR_NUM_HALVES-1:0] rise;
	logic [DNBR_NUM_HALVES-1:0] take;
	logic [DNBR_NUM_HALVES-1:0][DNBR_HALF_W-1:0] store_d;

	// the halves share only sys_clk and nrst; an 18-bit register is both
	// control sets driven alike, lo giving bits 8:0 and hi bits 17:9

	// one bundle layout serves the packer and every field reader below
	function automatic logic [DNBR_PIN_W-1:0] dnbr_pack
	(
		input logic clk,
		input logic load_n,
		input logic zero_n,
		input logic oe_n,
		input logic [DNBR_HALF_W-1:0] d
	);
		return {clk, load_n, zero_n, oe_n, d};
	endfunction

	// half clock level
	function automatic logic dnbr_clk_of
	(
		input logic [DNBR_PIN_W-1:0] p
	);
		return p[DNBR_POS_CLK];
	endfunction

	// load enable, low means load
	function automatic logic dnbr_load_n_of
	(
		input logic [DNBR_PIN_W-1:0] p
	);
		return p[DNBR_POS_LOAD_N];
	endfunction

	// clear, low means zero the store
	function automatic logic dnbr_zero_n_of
	(
		input logic [DNBR_PIN_W-1:0] p
	);
		return p[DNBR_POS_ZERO_N];
	endfunction

	// output enable, low means drive
	function automatic logic dnbr_oe_n_of
	(
		input logic [DNBR_PIN_W-1:0] p
	);
		return p[DNBR_POS_OE_N];
	endfunction

	// data bits
	function automatic logic [DNBR_HALF_W-1:0] dnbr_data_of
	(
		input logic [DNBR_PIN_W-1:0] p
	);
		return p[DNBR_POS_DATA +: DNBR_HALF_W];
	endfunction

	// a rise is the synchronised clock high now and low one sys_clk earlier;
	// a clock pulse shorter than one sys_clk period can be missed entirely
	function automatic logic dnbr_rise
	(
		input logic now_lvl,
		input logic prev_lvl
	);
		return now_lvl && !prev_lvl;
	endfunction

	// clear wins over a load that lands in the same synchronised cycle
	function automatic logic dnbr_take
	(
		input logic rise_now,
		input logic load_n,
		input logic zero_n
	);
		return rise_now && !load_n && zero_n;
	endfunction

	// next store of one half: clear first, then an enabled rise, else hold
	function automatic logic [DNBR_HALF_W-1:0] dnbr_store_next
	(
		input logic zero_n,
		input logic take_now,
		input logic [DNBR_HALF_W-1:0] d,
		input logic [DNBR_HALF_W-1:0] cur
	);
		if (!zero_n)
		begin
			return DNBR_STORE_RST;
		end
		if (take_now)
		begin
			return d;
		end
		// load enable high or no rise: edge ignored, store holds
		return cur;
	endfunction

	// reset image: stores empty, drivers off, clocks taken as high so that a
	// clock already high at release is not seen as an edge
	function automatic dnbr_state_t dnbr_reset_state();
		dnbr_state_t r;
		for (int h = 0; h < DNBR_NUM_HALVES; h++)
		begin
			r.store[h] = DNBR_STORE_RST;
			r.drive_n[h] = DNBR_DRIVE_N_RST;
			r.clk_prev[h] = DNBR_CLK_PREV_RST;
		end
		return r;
	endfunction

	// every pin of both halves goes through the same two-stage delay, so data
	// stays aligned with the clock edge it is meant for
	assign pins[0] = dnbr_pack(lo_clk, lo_load_enable_n, lo_async_zero_n, lo_oe_n, lo_d);
	assign pins[1] = dnbr_pack(hi_clk, hi_load_enable_n, hi_async_zero_n, hi_oe_n, hi_d);

	dnbr_sync u_sync
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin_in(pins),
		.pin_sync(pins_s)
	);

	// field decode, one pass per half
	always_comb
	begin
		for (int h = 0; h < DNBR_NUM_HALVES; h++)
		begin
			clk_s[h] = dnbr_clk_of(pins_s[h]);
			load_n_s[h] = dnbr_load_n_of(pins_s[h]);
			zero_n_s[h] = dnbr_zero_n_of(pins_s[h]);
			oe_n_s[h] = dnbr_oe_n_of(pins_s[h]);
			data_s[h] = dnbr_data_of(pins_s[h]);
			rise[h] = dnbr_rise(clk_s[h], st.clk_prev[h]);
			take[h] = dnbr_take(rise[h], load_n_s[h], zero_n_s[h]);
			store_d[h] = dnbr_store_next(zero_n_s[h], take[h], data_s[h], st.store[h]);
		end
	end

	always_comb
	begin
		next_st = st;
		for (int h = 0; h < DNBR_NUM_HALVES; h++)
		begin
			next_st.clk_prev[h] = clk_s[h];
			// output enable only steers the driver, storage ignores it
			next_st.drive_n[h] = oe_n_s[h];
			next_st.store[h] = store_d[h];
		end
		if (!nrst)
		begin
			next_st = dnbr_reset_state();
		end
	end

	// one register for the whole state; reset is synchronous through next_st
	always_ff @(posedge sys_clk)
	begin
		st <= next_st;
	end

	// outputs straight from flops; the pad cell turns a high q_oe_n into
	// high impedance, which the bus model mirrors
	assign lo_q = st.store[0];
	assign hi_q = st.store[1];
	assign lo_q_oe_n = st.drive_n[0];
	assign hi_q_oe_n = st.drive_n[1];
endmodule
`default_nettype wire

// >>> pkg/dnbr_pkg.sv
`default_nettype none
package dnbr_pkg;
	localparam int DNBR_HALF_W = 9;
	localparam int DNBR_NUM_HALVES = 2;
	// pin bundle per half: {clk, load_enable_n, async_zero_n, oe_n, data}
	localparam int DNBR_PIN_W = DNBR_HALF_W + 4;
	localparam int DNBR_POS_DATA = 0;
	localparam int DNBR_POS_OE_N = DNBR_HALF_W;
	localparam int DNBR_POS_ZERO_N = DNBR_HALF_W + 1;
	localparam int DNBR_POS_LOAD_N = DNBR_HALF_W + 2;
	localparam int DNBR_POS_CLK = DNBR_HALF_W + 3;
	localparam logic [DNBR_HALF_W-1:0] DNBR_STORE_RST = 9'h000;
	localparam logic DNBR_DRIVE_N_RST = 1'b1;
	localparam logic DNBR_CLK_PREV_RST = 1'b1;
	// synchroniser reset value: controls inactive, clock high so no false edge
	localparam logic [DNBR_PIN_W-1:0] DNBR_SYNC_RST = 13'h1e00;
endpackage
`default_nettype wire

// >>> rtl/dnbr_sync.sv
`default_nettype none
module dnbr_sync
	import dnbr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// pins in, synchronised out
	input wire logic [DNBR_NUM_HALVES-1:0][DNBR_PIN_W-1:0] pin_in,
	output logic [DNBR_NUM_HALVES-1:0][DNBR_PIN_W-1:0] pin_sync
);
	typedef struct packed
	{
		logic [DNBR_NUM_HALVES-1:0][DNBR_PIN_W-1:0] s1;
		logic [DNBR_NUM_HALVES-1:0][DNBR_PIN_W-1:0] s2;
	} dnbr_sync_state_t;

	dnbr_sync_state_t st;
	dnbr_sync_state_t next_st;

	always_comb
	begin
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		if (!nrst)
		begin
			next_st.s1 = {DNBR_NUM_HALVES{DNBR_SYNC_RST}};
			next_st.s2 = {DNBR_NUM_HALVES{DNBR_SYNC_RST}};
		end
	end

	always_ff @(posedge sys_clk)
	begin
		st <= next_st;
	end

	assign pin_sync = st.s2;
endmodule
`default_nettype wire

// >>> test/dnbr_bus.sv
`default_nettype none
module dnbr_bus (
	input wire logic [8:0] lo_q, hi_q,
	input wire logic lo_q_oe_n, hi_q_oe_n,
	output wire logic [17:0] bus_w
);
	timeunit 1ns / 1ns;
	// no keeper on this bus, so a released half reads z rather than a stale value
	assign bus_w = {hi_q_oe_n ? 9'hzzz : hi_q, lo_q_oe_n ? 9'hzzz : lo_q};
endmodule
`default_nettype wire

// >>> test/dnbr_properties.sv
`default_nettype none
module dnbr_chk (
	input wire logic sys_clk, nrst, lo_clk, lo_load_enable_n, lo_async_zero_n, lo_oe_n,
	input wire logic lo_q_oe_n,
	input wire logic [8:0] lo_d, lo_q
);
	timeunit 1ns / 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_ld; $rose(lo_clk) && !lo_load_enable_n && lo_async_zero_n
		|-> ##3 lo_q == $past(lo_d, 3); endproperty
	a_ld: assert property (p_ld) else $error("load");
	property p_hold; $changed(lo_q) && $past(lo_async_zero_n, 3)
		|-> !$past(lo_load_enable_n, 3); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_clr; $fell(lo_async_zero_n) |-> ##3 lo_q == 0; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_zz; !$past(lo_async_zero_n, 3) |-> lo_q == 0; endproperty
	a_zz: assert property (p_zz) else $error("clear held");
	property p_zr; $rose(lo_async_zero_n) && !$rose(lo_clk) |-> ##3 lo_q == 0; endproperty
	a_zr: assert property (p_zr) else $error("clear release");
	property p_on; $fell(lo_oe_n) |-> ##3 !lo_q_oe_n; endproperty
	a_on: assert property (p_on) else $error("drive");
	property p_off; $rose(lo_oe_n) |-> ##3 lo_q_oe_n; endproperty
	a_off: assert property (p_off) else $error("float");
	// an event seen at the pins three edges ago is the only thing that may move q
	property p_oeq; $rose(lo_oe_n) && lo_load_enable_n && lo_async_zero_n
		|-> ##3 $stable(lo_q); endproperty
	a_oeq: assert property (p_oeq) else $error("oe moved q");
endmodule
bind dnbr_top dnbr_chk chk (.*);
`default_nettype wire

// >>> test/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns / 1ns;
	logic sys_clk = 0, nrst = 0, lo_clk = 0, lo_oe_n = 1, lo_async_zero_n = 1;
	logic lo_load_enable_n = 1, lo_q_oe_n, hi_q_oe_n;
	logic [8:0] lo_d = 0, lo_q, hi_q;
	// high half mirrors the low pins with inverted data; only its clear is kept apart
	wire logic hi_clk = lo_clk, hi_oe_n = lo_oe_n, hi_load_enable_n = lo_load_enable_n;
	logic hi_async_zero_n = 1'h1;
	wire logic [8:0] hi_d = ~lo_d;
	wire logic [17:0] bus_w;
	int err_count = 0, cmp_count = 0;
	dnbr_top dut (.*);
	dnbr_bus bus (.*);
	initial forever #5 sys_clk = ~sys_clk;
	// each clock level held 3 cycles so the two-stage synchroniser sees it
	task step(input logic [8:0] v, input logic en_n, input logic [17:0] e);
		lo_d = v;
		lo_load_enable_n = en_n;
		repeat (3) @(negedge sys_clk);
		lo_clk = 1;
		repeat (3) @(negedge sys_clk);
		lo_clk = 0;
		repeat (4) @(negedge sys_clk);
		cmp_count++;
		if (bus_w !== e)
		begin
			err_count++;
			$display("mismatch %0t bus %h", $time, bus_w);
		end
	endtask
	task t_load;
		lo_oe_n = 0;
		step(9'h1c3, 0, 18'h079c3);
		step(9'h0a5, 1, 18'h079c3);
		$display("load test end");
	endtask
	task t_oe;
		lo_oe_n = 1;
		step(9'h0f0, 0, 18'hzzzzz);
		lo_oe_n = 0;
		step(9'h0f0, 1, 18'h21ef0);
		$display("oe test end");
	endtask
	task t_clear;
		lo_async_zero_n = 0;
		step(9'h155, 0, 18'h15400);
		lo_async_zero_n = 1;
		step(9'h155, 1, 18'h15400);
		hi_async_zero_n = 1'h0;
		step(9'h0aa, 0, 18'h000aa);
		hi_async_zero_n = 1'h1;
		$display("clear test end");
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(negedge sys_clk);
		nrst = 1;
		t_load;
		t_oe;
		t_clear;
		print_verdict;
	end
endmodule
`default_nettype wire
